// ---- dv/board_pad_model.sv ----
// Board-side model of the signals attached to each port pad.
// Assumes the block's pad outputs; resolves one level per pad for pad_in.
`timescale 1ns/1ps
module board_pad_model (
   // Clock for the floating-line pattern
   input  wire logic                                aclk,
   // Cell side of each pad
   input  wire logic [port_cell_pkg::NUM_PINS-1:0] pad_out,
   input  wire logic [port_cell_pkg::NUM_PINS-1:0] pad_oe,
   input  wire logic [port_cell_pkg::NUM_PINS-1:0] pad_pullup_en,
   // External board drivers
   input  wire logic [port_cell_pkg::NUM_PINS-1:0] ext_val,
   input  wire logic [port_cell_pkg::NUM_PINS-1:0] ext_en,
   output      logic [port_cell_pkg::NUM_PINS-1:0] pad_in
);
   logic [port_cell_pkg::NUM_PINS-1:0] float_pat = '0;

   ////////////////////////////////////////////////////////////////////////////
   // Undriven, unpulled pad wanders so an unknown never settles by luck
   always @(posedge aclk) begin
      float_pat <= ~float_pat;
   end

   // Cell driver first, then board driver, then weak pull-up
   always_comb begin
      for (int i = 0; i < port_cell_pkg::NUM_PINS; i++) begin
         if (pad_oe[i]) pad_in[i] = pad_out[i];
         else if (ext_en[i]) pad_in[i] = ext_val[i];
         else if (pad_pullup_en[i]) pad_in[i] = 1'b1;
         else pad_in[i] = float_pat[i];
      end
   end
endmodule

// ---- dv/tb_top.sv ----
// Self-checking bench for the port block: AXI4-Lite master, pad checks, read queue.
// Assumes the board model drives pad_in; debug link driven only in its own test.
`timescale 1ns/1ps
module tb_top;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [5:0]  awaddr = '0, araddr = '0;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0] wdata = '0;
   logic [3:0]  wstrb = '0;
   logic        awready, wready, bvalid, arready, rvalid, dbg_in;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [23:0] periph = '0, pin_in, pad_in, pad_out, pad_oe, pad_pu, pad_rx;
   logic [23:0] ext_val = '0, ext_en = '0;
   logic [23:0] latch, imode, omode, route;
   logic        gpd;
   logic        dbg_act = 1'b0, dbg_out = 1'b0, dbg_oe = 1'b0;
   logic [33:0] exp_q[$];
   int          fail_count = 0, num_checks = 0, cycles = 0, seed;

   always #10 aclk = ~aclk;

   port_pin_mode_cell port_pin_mode_cell_i (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .periph_out(periph), .pin_in_data(pin_in), .pad_in(pad_in), .pad_out(pad_out),
      .pad_oe(pad_oe), .pad_pullup_en(pad_pu), .pad_receiver_en(pad_rx),
      .debug_link_active(dbg_act), .debug_link_data_out(dbg_out), .debug_link_data_oe(dbg_oe),
      .debug_link_data_in(dbg_in));

   board_pad_model board_pad_model_i (.aclk(aclk), .pad_out(pad_out), .pad_oe(pad_oe),
      .pad_pullup_en(pad_pu), .ext_val(ext_val), .ext_en(ext_en), .pad_in(pad_in));

   ////////////////////////////////////////////////////////////////////////////
   // Comparison and closing
   task automatic check(input logic [33:0] seen, input logic [33:0] exp, input string what);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("FAIL %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // Hang guard, well above the few hundred cycles the tests need
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         complete_run();
      end
   end

   // Read results are matched against the oldest queued note
   always @(posedge aclk) begin
      if (rvalid === 1'b1 && rready) begin
         if (exp_q.size() == 0) check(34'h0, 34'h1, "unexpected read");
         else check({rresp, rdata}, exp_q.pop_front(), "read data");
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite master tasks; the bench timeout bounds every wait
   task automatic axi_write(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s,
                            input logic [1:0] eresp);
      @(posedge aclk);
      awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1; wvalid <= 1; bready <= 1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 0;
         if (wvalid && wready) wvalid <= 0;
      end while (bvalid !== 1'b1);
      bready <= 0;
      check(bresp, eresp, "write response");
   endtask

   task automatic axi_read(input logic [5:0] a, input logic [1:0] eresp, input logic [31:0] ed);
      exp_q.push_back({eresp, ed});
      @(posedge aclk);
      araddr <= a; arvalid <= 1; rready <= 1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 0;
      end while (rvalid !== 1'b1);
      rready <= 0;
   endtask

   // Pad outputs and read-back worked out from the bench's register copy
   task automatic check_pads();
      logic [23:0] d, eo, ep, v;
      repeat (4) @(posedge aclk);
      for (int i = 0; i < 24; i++) begin
         d[i]  = (route[i] && i != port_cell_pkg::DEBUG_PIN) ? periph[i] : latch[i];
         eo[i] = omode[i] | ~d[i];
         ep[i] = imode[i] & ~eo[i] & ~gpd;
         v[i]  = (eo[i] ? d[i] : (ext_en[i] ? ext_val[i] : ep[i])) & imode[i];
      end
      check(pad_oe, eo, "output enable");
      check(pad_out & eo, d & eo, "drive value");
      check(pad_pu, ep, "pull-up");
      check(pad_rx, imode, "receiver");
      check(pin_in, v, "pin input");
      axi_read(port_cell_pkg::OFF_PORT_VALUE, port_cell_pkg::RESP_OKAY, {8'h00, v});
   endtask

   // Bench register copy back to its reset values
   task automatic reset_copy();
      latch = port_cell_pkg::RST_LATCH;
      imode = port_cell_pkg::RST_INPUT_MODE;
      omode = port_cell_pkg::RST_OUTPUT_MODE;
      route = port_cell_pkg::RST_ROUTE_SEL;
      gpd = port_cell_pkg::RST_GLOBAL_PUD;
   endtask

   task automatic write_config();
      axi_write(port_cell_pkg::OFF_PORT_LATCH, {8'h00, latch}, 4'hF, port_cell_pkg::RESP_OKAY);
      axi_write(port_cell_pkg::OFF_INPUT_MODE, {8'h00, imode}, 4'hF, port_cell_pkg::RESP_OKAY);
      axi_write(port_cell_pkg::OFF_OUTPUT_MODE, {8'h00, omode}, 4'hF, port_cell_pkg::RESP_OKAY);
      axi_write(port_cell_pkg::OFF_ROUTE_SEL, {8'h00, route}, 4'hF, port_cell_pkg::RESP_OKAY);
      axi_write(port_cell_pkg::OFF_GLOBAL_CTRL, {31'h0, gpd}, 4'hF, port_cell_pkg::RESP_OKAY);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      seed = $urandom(95);
      reset_copy();
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      periph <= 24'($urandom);
      repeat (2) @(posedge aclk);
      // Reset state: digital, undriven, pulled up
      check_pads();
      axi_read(port_cell_pkg::OFF_INPUT_MODE, port_cell_pkg::RESP_OKAY, 32'h00FFFFFF);
      axi_read(port_cell_pkg::OFF_GLOBAL_CTRL, port_cell_pkg::RESP_OKAY, 32'h0);
      axi_read(6'h18, port_cell_pkg::RESP_SLVERR, 32'h0);
      $display("test reset state done");
      // Random modes, drives, routes and board levels
      for (int n = 0; n < 8; n++) begin
         latch = 24'($urandom);
         imode = 24'($urandom);
         omode = 24'($urandom);
         route = 24'($urandom);
         gpd = n[0];
         ext_en <= 24'hFFFFFF;
         ext_val <= 24'($urandom);
         write_config();
         check_pads();
         axi_read(port_cell_pkg::OFF_OUTPUT_MODE, port_cell_pkg::RESP_OKAY, {8'h00, omode});
      end
      $display("test random pin modes done");
      // Outer bytes analog with latch drivers released by software, random routes kept, board driving the digital middle byte
      imode = 24'h00FF00;
      omode = '0;
      latch = 24'hFFFFFF;
      gpd = 1'b0;
      ext_en <= 24'h00FF00;
      write_config();
      check_pads();
      $display("test analog release done");
      // Lane-masked write, ignored port value write, unmapped write
      axi_write(port_cell_pkg::OFF_PORT_LATCH, 32'h0, 4'h2, port_cell_pkg::RESP_OKAY);
      latch[15:8] = 8'h00;
      axi_write(port_cell_pkg::OFF_PORT_VALUE, 32'h0, 4'hF, port_cell_pkg::RESP_OKAY);
      axi_write(6'h1C, 32'hFFFFFFFF, 4'hF, port_cell_pkg::RESP_SLVERR);
      axi_read(port_cell_pkg::OFF_PORT_LATCH, port_cell_pkg::RESP_OKAY, {8'h00, latch});
      check_pads();
      repeat (3) @(posedge aclk);
      check(exp_q.size(), 0, "pending reads");
      $display("test lanes and refusals done");
      // Debug link owns the top pin; its pad level comes back synchronised
      dbg_act <= 1'b1;
      dbg_oe  <= 1'b1;
      for (int b = 0; b < 2; b++) begin
         dbg_out <= b[0];
         repeat (8) @(posedge aclk);
         check({pad_oe[23], pad_out[23], dbg_in}, {1'b1, b[0], b[0]}, "debug pin");
      end
      dbg_act <= 1'b0;
      dbg_oe  <= 1'b0;
      $display("test debug pin done");
      // Second reset in mid-run restores the reset state
      aresetn <= 1'b0;
      reset_copy();
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      check_pads();
      axi_read(port_cell_pkg::OFF_PORT_LATCH, port_cell_pkg::RESP_OKAY, {8'h00, latch});
      $display("test mid-run reset done");
      complete_run();
   end
endmodule

// ---- verilog/pad_sync.sv ----
// Two-stage synchroniser for a vector of pad inputs.
// Assumes the inputs are asynchronous to aclk.
`timescale 1ns/1ps
module pad_sync #(
   parameter int WIDTH = 24
) (
   // Clock and reset
   input  wire logic             aclk,
   input  wire logic             aresetn,
   // Data
   input  wire logic [WIDTH-1:0] async_in,
   output      logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;

   // First stage is read only by the second stage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stage1   <= '0;
         sync_out <= '0;
      end else begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end
endmodule

// ---- verilog/port_cell_pkg.sv ----
// Constants for the general-purpose port block: register map, fields, reset values.
// Assumes a 32-bit AXI4-Lite slave at 50 MHz with one aligned word per register.
// Functional notes
// - Each pin has an input-mode bit where 0 means analog and 1 means digital.
// - After reset every pin is digital, undriven, with its weak pull-up on.
// - An analog pin has its weak pull-up and digital receiver switched off.
// - A read of an analog pin returns 0 whatever the pad shows.
// - A digital pin with its output-mode bit set drives push-pull, otherwise open-drain.
// - In open-drain mode the high side never drives; 0 pulls low and 1 releases the pad.
// - A digital pin that is not driving has its weak pull-up on.
// - The weak pull-up is off while the pin drives the pad low.
// - One global pull-up disable bit set to 1 turns off all weak pull-ups.
// - A read of a digital pin returns the sampled pad level, not the output value.
// - Pins form three byte-wide ports, 24 pins on the large variant and 16 on the small one.
// - Each digital pin is fed by a peripheral or by its general-purpose latch, as software selects.
// - The top pin of the third port is general-purpose only and shares its pad with debug data.
package port_cell_pkg;
   localparam int          NUM_PORTS       = 3;
   localparam int          PORT_WIDTH      = 8;
   localparam int          NUM_PINS        = NUM_PORTS * PORT_WIDTH;
   localparam int          ADDR_WIDTH      = 6;
   // Register byte offsets
   localparam logic [5:0]  OFF_PORT_LATCH  = 6'h00;
   localparam logic [5:0]  OFF_PORT_VALUE  = 6'h04;
   localparam logic [5:0]  OFF_INPUT_MODE  = 6'h08;
   localparam logic [5:0]  OFF_OUTPUT_MODE = 6'h0C;
   localparam logic [5:0]  OFF_ROUTE_SEL   = 6'h10;
   localparam logic [5:0]  OFF_GLOBAL_CTRL = 6'h14;
   // Field positions
   localparam int          GLOBAL_PUD_BIT  = 0;
   localparam int          DEBUG_PIN       = 23;
   // Reset values
   localparam logic [23:0] RST_LATCH       = 24'hFFFFFF;
   localparam logic [23:0] RST_INPUT_MODE  = 24'hFFFFFF;
   localparam logic [23:0] RST_OUTPUT_MODE = 24'h000000;
   localparam logic [23:0] RST_ROUTE_SEL   = 24'h000000;
   localparam logic        RST_GLOBAL_PUD  = 1'b0;
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;
   localparam int          SYNC_STAGES     = 2;
endpackage

// ---- verilog/port_pin_mode_cell.sv ----
// General-purpose port block: per-pin mode, drive, pull-up and pad read-back.
// Assumes an AXI4-Lite master on aclk and pad wiring resolved outside from the enables.
`timescale 1ns/1ps
module port_pin_mode_cell #(
   parameter int NUM_PINS = port_cell_pkg::NUM_PINS
) (
   // Clock and reset
   input  wire logic                aclk,
   input  wire logic                aresetn,
   // AXI4-Lite write address
   input  wire logic [5:0]          s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output      logic                s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output      logic                s_axi_wready,
   // AXI4-Lite write response
   output      logic [1:0]          s_axi_bresp,
   output      logic                s_axi_bvalid,
   input  wire logic                s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [5:0]          s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output      logic                s_axi_arready,
   // AXI4-Lite read data
   output      logic [31:0]         s_axi_rdata,
   output      logic [1:0]          s_axi_rresp,
   output      logic                s_axi_rvalid,
   input  wire logic                s_axi_rready,
   // Peripheral side of the routing stage
   input  wire logic [NUM_PINS-1:0] periph_out,
   output      logic [NUM_PINS-1:0] pin_in_data,
   // Pads
   input  wire logic [NUM_PINS-1:0] pad_in,
   output      logic [NUM_PINS-1:0] pad_out,
   output      logic [NUM_PINS-1:0] pad_oe,
   output      logic [NUM_PINS-1:0] pad_pullup_en,
   output      logic [NUM_PINS-1:0] pad_receiver_en,
   // Debug link data shares the top pin
   input  wire logic                debug_link_active,
   input  wire logic                debug_link_data_out,
   input  wire logic                debug_link_data_oe,
   output      logic                debug_link_data_in
);

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [NUM_PINS-1:0] port_latch;
   logic [NUM_PINS-1:0] pin_input_mode_select;
   logic [NUM_PINS-1:0] pin_output_mode_select;
   logic [NUM_PINS-1:0] route_select;
   logic                global_pullup_disable;
   logic [NUM_PINS-1:0] pad_level;
   logic                dbg_active_s1;
   logic                dbg_active;

   // Debug-active comes from another clock domain, so it is synchronised
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dbg_active_s1 <= 1'b0;
         dbg_active    <= 1'b0;
      end else begin
         dbg_active_s1 <= debug_link_active;
         dbg_active    <= dbg_active_s1;
      end
   end

   // Pad levels pass two flops before any read path sees them
   pad_sync #(
      .WIDTH    (NUM_PINS)
   ) u_pad_sync (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .async_in (pad_in),
      .sync_out (pad_level)
   );

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write channel
   logic       aw_held;
   logic       w_held;
   logic [5:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   wire        aw_take  = s_axi_awvalid && s_axi_awready;
   wire        w_take   = s_axi_wvalid && s_axi_wready;
   wire        wr_fire  = aw_held && w_held && !s_axi_bvalid;
   wire [5:0]  wr_word  = {aw_addr[5:2], 2'b00};
   wire        wr_latch = (wr_word == port_cell_pkg::OFF_PORT_LATCH);
   wire        wr_value = (wr_word == port_cell_pkg::OFF_PORT_VALUE);
   wire        wr_imode = (wr_word == port_cell_pkg::OFF_INPUT_MODE);
   wire        wr_omode = (wr_word == port_cell_pkg::OFF_OUTPUT_MODE);
   wire        wr_route = (wr_word == port_cell_pkg::OFF_ROUTE_SEL);
   wire        wr_glob  = (wr_word == port_cell_pkg::OFF_GLOBAL_CTRL);
   wire        wr_hit   = wr_latch || wr_value || wr_imode || wr_omode || wr_route || wr_glob;
   wire [23:0] byte_mask = {{8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

   // Merge helper: byte enables keep untouched lanes
   function automatic logic [23:0] merge(input logic [23:0] old_v, input logic [31:0] new_v,
                                         input logic [23:0] mask);
      merge = (old_v & ~mask) | (new_v[23:0] & mask);
   endfunction

   // Address and data held separately so either may arrive first
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= 6'h00;
         w_data  <= 32'h00000000;
         w_strb  <= 4'h0;
      end else begin
         if (aw_take) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_held <= 1'b0;
         end
         if (w_take) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_held <= 1'b0;
         end
      end
   end

   // Ready low while a beat is held or the response waits
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held && !aw_take && !s_axi_bvalid;
         s_axi_wready  <= !w_held && !w_take && !s_axi_bvalid;
      end
   end

   // Write response; unmapped addresses answer SLVERR
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= port_cell_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? port_cell_pkg::RESP_OKAY : port_cell_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Register storage; port value is read-only, writes to it are dropped
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         port_latch             <= port_cell_pkg::RST_LATCH;
         pin_input_mode_select  <= port_cell_pkg::RST_INPUT_MODE;
         pin_output_mode_select <= port_cell_pkg::RST_OUTPUT_MODE;
         route_select           <= port_cell_pkg::RST_ROUTE_SEL;
         global_pullup_disable  <= port_cell_pkg::RST_GLOBAL_PUD;
      end else if (wr_fire) begin
         if (wr_latch) port_latch <= merge(port_latch, w_data, byte_mask);
         if (wr_imode) pin_input_mode_select <= merge(pin_input_mode_select, w_data, byte_mask);
         if (wr_omode) pin_output_mode_select <= merge(pin_output_mode_select, w_data, byte_mask);
         if (wr_route) route_select <= merge(route_select, w_data, byte_mask);
         if (wr_glob && w_strb[0]) begin
            global_pullup_disable <= w_data[port_cell_pkg::GLOBAL_PUD_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin cell logic
   logic [NUM_PINS-1:0] next_pad_out;
   logic [NUM_PINS-1:0] next_pad_oe;
   logic [NUM_PINS-1:0] next_pullup;
   logic [NUM_PINS-1:0] next_recv;
   logic [NUM_PINS-1:0] port_value;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
         // Top pin cannot take a peripheral; it hands over to debug when active
         wire is_dbg   = (gi == port_cell_pkg::DEBUG_PIN);
         wire use_per  = route_select[gi] && !is_dbg;
         wire out_val  = use_per ? periph_out[gi] : port_latch[gi];
         wire dbg_own  = is_dbg && dbg_active;
         wire digital  = pin_input_mode_select[gi];
         // Analog mode leaves the driver as software set it
         wire drv_low  = !out_val;
         wire drv_high = out_val && pin_output_mode_select[gi];
         wire oe_cell  = dbg_own ? debug_link_data_oe : (drv_low || drv_high);
         wire o_cell   = dbg_own ? debug_link_data_out : out_val;
         wire low_now  = oe_cell && !o_cell;
         assign next_pad_out[gi] = o_cell;
         assign next_pad_oe[gi]  = oe_cell;
         // Pull-up only on an idle digital pin, never while driving low
         assign next_pullup[gi]  = digital && !oe_cell && !low_now
                                   && !global_pullup_disable;
         assign next_recv[gi]    = digital;
         assign port_value[gi]   = digital ? pad_level[gi] : 1'b0;
      end
   endgenerate

   // Pad outputs registered so every output comes from a flop
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pad_out            <= '1;
         pad_oe             <= '0;
         pad_pullup_en      <= '1;
         pad_receiver_en    <= '1;
         pin_in_data        <= '0;
         debug_link_data_in <= 1'b0;
      end else begin
         pad_out            <= next_pad_out;
         pad_oe             <= next_pad_oe;
         pad_pullup_en      <= next_pullup;
         pad_receiver_en    <= next_recv;
         pin_in_data        <= port_value;
         debug_link_data_in <= pad_level[port_cell_pkg::DEBUG_PIN];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read channel
   wire [5:0]  rd_word = {s_axi_araddr[5:2], 2'b00};
   wire        ar_take = s_axi_arvalid && s_axi_arready;
   logic [31:0] rd_mux;
   logic        rd_hit;

   // Read decode; bits above the pin field read as zero
   always_comb begin
      rd_mux = 32'h00000000;
      rd_hit = 1'b1;
      case (rd_word)
         port_cell_pkg::OFF_PORT_LATCH:  rd_mux = {8'h00, port_latch};
         port_cell_pkg::OFF_PORT_VALUE:  rd_mux = {8'h00, port_value};
         port_cell_pkg::OFF_INPUT_MODE:  rd_mux = {8'h00, pin_input_mode_select};
         port_cell_pkg::OFF_OUTPUT_MODE: rd_mux = {8'h00, pin_output_mode_select};
         port_cell_pkg::OFF_ROUTE_SEL:   rd_mux = {8'h00, route_select};
         port_cell_pkg::OFF_GLOBAL_CTRL: rd_mux = {31'h00000000, global_pullup_disable};
         default:                        rd_hit = 1'b0;
      endcase
   end

   // One read at a time; arready drops while data waits
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= port_cell_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !ar_take;
         if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_hit ? port_cell_pkg::RESP_OKAY : port_cell_pkg::RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   sequence s_wr_done;
      wr_fire ##1 s_axi_bvalid;
   endsequence

   a_analog_reads_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      !pin_input_mode_select[0] |-> ##1 !pin_in_data[0])
      else $error("analog pin read back non-zero");
   a_analog_no_pullup: assert property (@(posedge aclk) disable iff (!aresetn)
      !pin_input_mode_select[1] |=> !pad_pullup_en[1] && !pad_receiver_en[1])
      else $error("analog pin kept pull-up or receiver");
   a_open_drain_high: assert property (@(posedge aclk) disable iff (!aresetn)
      !pin_output_mode_select[2] && !route_select[2] && port_latch[2] |=> !pad_oe[2])
      else $error("open-drain pin drove high");
   a_push_pull_drive: assert property (@(posedge aclk) disable iff (!aresetn)
      pin_output_mode_select[3] && !route_select[3] |=> pad_oe[3] && pad_out[3] == $past(port_latch[3]))
      else $error("push-pull pin not driving latch value");
   a_low_no_pullup: assert property (@(posedge aclk) disable iff (!aresetn)
      pad_oe[4] && !pad_out[4] |-> !pad_pullup_en[4])
      else $error("pull-up on while driving low");
   a_global_disable: assert property (@(posedge aclk) disable iff (!aresetn)
      global_pullup_disable |=> pad_pullup_en == '0)
      else $error("pull-up on despite global disable");
   a_idle_pullup: assert property (@(posedge aclk) disable iff (!aresetn)
      pin_input_mode_select[5] && !next_pad_oe[5] && !global_pullup_disable |=> pad_pullup_en[5])
      else $error("idle digital pin lacks pull-up");
   a_pad_readback: assert property (@(posedge aclk) disable iff (!aresetn)
      pin_input_mode_select[6] |-> ##1 pin_in_data[6] == $past(pad_level[6]))
      else $error("digital read not pad level");
   a_sync_delay: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn, 2) |-> pad_level == $past(pad_in, 2))
      else $error("pad level not two cycles late");
   // A pending response must hold off the next address and data beat
   a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
      s_wr_done |-> !s_axi_awready && !s_axi_wready)
      else $error("write beat accepted while response pending");
   a_debug_pin_gpio: assert property (@(posedge aclk) disable iff (!aresetn)
      !dbg_active && pin_output_mode_select[port_cell_pkg::DEBUG_PIN]
      |=> pad_out[port_cell_pkg::DEBUG_PIN] == $past(port_latch[port_cell_pkg::DEBUG_PIN]))
      else $error("top pin not driven from latch");
endmodule
